// ### bench/lsag_cam_model.sv
// Stand-in for the line-scan camera link and the DMA sink of the acquisition gate.
// Assumes the block's CLK and RST; one line every PER cycles, NPIX pixel words a line.
`timescale 1ns/10ps
`default_nettype none
module lsag_cam_model #(
	parameter int PER  = 60,
	parameter int NPIX = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         slow,
	input  wire logic         pix_ready,
	output logic              line_boundary,
	output logic              cycle_begin,
	output logic [127:0]      meta,
	output logic              pix_valid,
	output logic [31:0]       pix_data,
	output logic              pix_last,
	output logic              dma_ready
);
	int          ph_q;
	logic [15:0] wd_q;
	logic [15:0] ln_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_q <= 0;
			wd_q <= '0;
			ln_q <= '0;
			line_boundary <= 1'b0;
			cycle_begin <= 1'b0;
			meta <= '0;
			pix_valid <= 1'b0;
			pix_data <= '0;
			pix_last <= 1'b0;
			dma_ready <= 1'b0;
		end else begin
			ph_q <= (ph_q == PER - 1) ? 0 : ph_q + 1;
			line_boundary <= (ph_q == PER - 1);
			// Cycle begin ahead of the boundary keeps a line's metadata stable while it moves
			cycle_begin <= (ph_q == PER - 7);
			dma_ready <= slow ? ~dma_ready : 1'b1;
			if (ph_q == PER - 7) begin
				ln_q <= ln_q + 16'h0001;
				meta <= {ln_q, 16'h3333, ln_q, 16'h2222, ln_q, 16'h1111, ln_q, 16'h0000};
			end
			if (line_boundary) begin
				wd_q <= 16'h0001;
				pix_valid <= 1'b1;
				pix_data <= 32'hA5A5_0000;
				pix_last <= (NPIX == 1);
			end else if (pix_valid && pix_ready) begin
				wd_q <= wd_q + 16'h0001;
				pix_valid <= (wd_q != NPIX);
				pix_data <= {16'hA5A5, wd_q};
				pix_last <= (wd_q == NPIX - 1);
			end else if (!pix_valid) begin
				// Idle data keeps changing so no stale word can pass as valid
				pix_data <= ~pix_data;
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/lsag_tb_top.sv
// Self-checking bench for the line-scan acquisition gate: registers, scans, buffer packing.
// Assumes the camera stand-in sends four pixel words a line, one line every 60 cycles.
`timescale 1ns/10ps
`default_nettype none
module lsag_tb_top
	import lsag_pkg::*;
;
	logic         CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
	logic         RREADY = 1'b0, EV1 = 1'b0, EV2 = 1'b0, slow = 1'b1;
	logic [7:0]   AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0]  WDATA = 32'h0;
	logic         AWREADY, WREADY, BVALID, ARREADY, RVALID, LINE_BOUNDARY, CYC, PIX_VALID, PIX_LAST;
	logic         PIX_READY, DMA_VALID, DMA_READY, BUF_DONE, BUF_HDR_VALID, GATE;
	logic [1:0]   BRESP, RRESP;
	logic [31:0]  RDATA, PIX_DATA, DMA_ADDR, DMA_DATA;
	logic [15:0]  BUF_LINES;
	logic [127:0] META_IN, BUF_HDR_META, hx = 128'h0;
	int           w = 0, k = 0, ea, nwl = 8, pitch = 48, slots = 2, nbuf = 0, nlines = 0;
	int           err_total = 0, n_compared = 0;
	logic         flip = 1'b0, hdr_exp = 1'b1, bnd_chk = 1'b0, gate_p = 1'b0, lb_p = 1'b0;
	logic [7:0]   ra [10] = '{OFF_CTRL, OFF_CONFIG, OFF_FIXED, OFF_LBYTES, OFF_STRIDE, OFF_SLOTS,
		OFF_STATUS, OFF_REPW, OFF_PAYLD, 8'h24};
	logic [31:0]  rv [10] = '{32'h0, 32'h0, 32'h1, 32'h100, 32'h0, 32'h10, 32'h0, 32'h100, 32'h1000, 32'h0};

	lsag_top dut (
		.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .LINE_BOUNDARY(LINE_BOUNDARY), .CAMERA_CYCLE_BEGIN(CYC),
		.INPUT_LINE_ONE_EVENT(EV1), .INPUT_LINE_TWO_EVENT(EV2), .META_IN(META_IN), .PIX_VALID(PIX_VALID),
		.PIX_DATA(PIX_DATA), .PIX_LAST(PIX_LAST), .PIX_READY(PIX_READY), .DMA_VALID(DMA_VALID),
		.DMA_ADDR(DMA_ADDR), .DMA_DATA(DMA_DATA), .DMA_READY(DMA_READY), .BUF_DONE(BUF_DONE),
		.BUF_LINES(BUF_LINES), .BUF_HDR_VALID(BUF_HDR_VALID), .BUF_HDR_META(BUF_HDR_META), .GATE(GATE)
	);
	lsag_cam_model cam (
		.clk(CLK), .rst(RST), .slow(slow), .pix_ready(PIX_READY), .line_boundary(LINE_BOUNDARY),
		.cycle_begin(CYC), .meta(META_IN), .pix_valid(PIX_VALID), .pix_data(PIX_DATA),
		.pix_last(PIX_LAST), .dma_ready(DMA_READY)
	);

	always #5 CLK = ~CLK;

	task automatic test_done();
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
		end while (BVALID !== 1'b1 && n < 50);
		BREADY <= 1'b0;
		cmp32(n < 50, 1);
		cmp32(BRESP, RESP_OKAY);
		if (n >= 50) test_done();
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
		int n;
		n = 0;
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1 && n < 50);
		RREADY <= 1'b0;
		cmp32(n < 50, 1);
		cmp32(RDATA, exp);
		cmp32(RRESP, rexp);
		if (n >= 50) test_done();
	endtask

	task automatic wait_gate(input logic v, input int lim);
		int n;
		n = 0;
		while (GATE !== v && n < lim) begin
			@(posedge CLK);
			n++;
		end
		cmp32(GATE, v);
		if (GATE !== v) test_done();
	endtask

	task automatic wlb();
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (LINE_BOUNDARY !== 1'b1 && n < 100);
		cmp32(n < 100, 1);
		if (n >= 100) test_done();
	endtask

	task automatic pulse(input logic [1:0] s);
		@(posedge CLK);
		{EV2, EV1} <= s;
		@(posedge CLK);
		{EV2, EV1} <= 2'b00;
	endtask

	// Expected slot and word order per scan, rebuilt from the gate opening
	always @(posedge CLK) begin
		if (GATE === 1'b1 && gate_p !== 1'b1) begin
			w = 0;
			k = 0;
		end
		if (GATE !== gate_p && (GATE === 1'b1 || bnd_chk)) cmp32(lb_p, 1);
		if (DMA_VALID === 1'b1 && DMA_READY === 1'b1) begin
			// First word of a buffer's first line: its header comes from the same cycle begin
			if (w == 0 && k % slots == 0) hx = META_IN;
			ea = (flip ? slots - 1 - k % slots : k % slots) * pitch + 4 * w;
			cmp32(DMA_ADDR, ea);
			if (w < 4) cmp32(DMA_DATA[15:0], w);
			else cmp32(DMA_DATA, META_IN[32 * (w - 4) +: 32]);
			w++;
			if (w == nwl) begin
				w = 0;
				k++;
			end
		end
		if (BUF_DONE === 1'b1) begin
			nbuf++;
			nlines += BUF_LINES;
			cmp32(BUF_HDR_VALID, hdr_exp);
			cmp32(BUF_LINES <= slots, 1);
			if (hdr_exp) for (int i = 0; i < 4; i++) cmp32(BUF_HDR_META[32 * i +: 32], hx[32 * i +: 32]);
		end
		gate_p = GATE;
		lb_p = LINE_BOUNDARY;
	end

	initial begin
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 10; i++) axr(ra[i], rv[i], i == 9 ? RESP_SLVERR : RESP_OKAY);
		axw(OFF_LBYTES, 32'h10);
		axw(OFF_SLOTS, 32'h2);
		axw(OFF_STRIDE, 32'h30);
		axw(OFF_CONFIG, 32'h60);
		axr(OFF_REPW, 32'h10, RESP_OKAY);
		axw(OFF_CONFIG, 32'hA0);
		axr(OFF_REPW, 32'h10, RESP_OKAY);
		axw(OFF_CONFIG, 32'hE0);
		axr(OFF_REPW, 32'h20, RESP_OKAY);
		axr(OFF_PAYLD, 32'h60, RESP_OKAY);
		// Continuous scan with a stalling DMA sink
		axw(OFF_CTRL, 32'h1);
		wait_gate(1'b1, 200);
		axw(OFF_CONFIG, 32'h0);
		axr(OFF_CONFIG, 32'hE0, RESP_OKAY);
		repeat (4) wlb();
		repeat (48) @(posedge CLK);
		axw(OFF_CTRL, 32'h2);
		wait_gate(1'b0, 4);
		repeat (4) @(posedge CLK);
		cmp32(nbuf, 3);
		cmp32(nlines, 5);
		axr(OFF_STATUS, 32'h0, RESP_OKAY);
		// Fixed-length scan, flipped, software begin
		axw(OFF_CONFIG, 32'h15);
		axw(OFF_FIXED, 32'h3);
		nwl = 4;
		flip = 1'b1;
		hdr_exp = 1'b0;
		slow <= 1'b0;
		axw(OFF_CTRL, 32'h1);
		axw(OFF_CTRL, 32'h8);
		axr(OFF_STATUS, 32'h0008_0000, RESP_OKAY);
		repeat (150) @(posedge CLK);
		cmp32(GATE, 0);
		axw(OFF_CTRL, 32'h4);
		wait_gate(1'b1, 80);
		axw(OFF_CTRL, 32'h4);
		wait_gate(1'b0, 400);
		repeat (4) @(posedge CLK);
		cmp32(nbuf, 5);
		cmp32(nlines, 8);
		// Variable-length scan on hardware events
		axw(OFF_CONFIG, 32'hE);
		flip = 1'b0;
		bnd_chk = 1'b1;
		pulse(2'b10);
		repeat (150) @(posedge CLK);
		cmp32(GATE, 0);
		pulse(2'b01);
		wait_gate(1'b1, 80);
		repeat (100) @(posedge CLK);
		pulse(2'b10);
		wait_gate(1'b0, 80);
		bnd_chk = 1'b0;
		pulse(2'b01);
		wait_gate(1'b1, 80);
		repeat (20) @(posedge CLK);
		axw(OFF_CTRL, 32'h2);
		wait_gate(1'b0, 4);
		test_done();
	end
endmodule
`default_nettype wire

// ### rtl/lsag_top.sv
// Line-scan acquisition gate: scan control, line packing, buffer release, metadata.
// Assumes line boundaries, cycle begins and trigger inputs are one-cycle pulses on CLK.
`timescale 1ns/10ps
`default_nettype none
module lsag_top
	import lsag_pkg::*;
#(
	parameter int SZW = 16
) (
	input  wire logic          CLK,
	input  wire logic          RST,
	input  wire logic [7:0]    AWADDR,
	input  wire logic          AWVALID,
	output var  logic          AWREADY,
	input  wire logic [31:0]   WDATA,
	input  wire logic [3:0]    WSTRB,
	input  wire logic          WVALID,
	output var  logic          WREADY,
	output var  logic [1:0]    BRESP,
	output var  logic          BVALID,
	input  wire logic          BREADY,
	input  wire logic [7:0]    ARADDR,
	input  wire logic          ARVALID,
	output var  logic          ARREADY,
	output var  logic [31:0]   RDATA,
	output var  logic [1:0]    RRESP,
	output var  logic          RVALID,
	input  wire logic          RREADY,
	input  wire logic          LINE_BOUNDARY,
	input  wire logic          CAMERA_CYCLE_BEGIN,
	input  wire logic          INPUT_LINE_ONE_EVENT,
	input  wire logic          INPUT_LINE_TWO_EVENT,
	input  wire logic [127:0]  META_IN,
	input  wire logic          PIX_VALID,
	input  wire logic [31:0]   PIX_DATA,
	input  wire logic          PIX_LAST,
	output var  logic          PIX_READY,
	output var  logic          DMA_VALID,
	output var  logic [31:0]   DMA_ADDR,
	output var  logic [31:0]   DMA_DATA,
	input  wire logic          DMA_READY,
	output var  logic          BUF_DONE,
	output var  logic [SZW-1:0] BUF_LINES,
	output var  logic          BUF_HDR_VALID,
	output var  logic [127:0]  BUF_HDR_META,
	output var  logic          GATE
);
	logic [7:0]     cfg_q;
	logic [SZW-1:0] fixed_q, lbytes_q, stride_q, slots_q;
	logic [3:0]     cmd_q;
	logic           wr_go, rd_go;
	logic [31:0]    rd_d;
	logic           rd_ok;
	lsag_scan_t     ss_q, ss_d;
	lsag_line_t     ls_q, ls_d;
	logic [SZW-1:0] lib_q, lscan_q, boff_q, lines_n;
	logic [1:0]     midx_q;
	logic [127:0]   lm_samp_q, lm_hold_q, hdr_q;
	logic           hdr_pend_q, hdr_got_q;
	logic           meta_ok, hdr_en, lm_en;
	logic [SZW-1:0] repw, pitch, slot;
	logic [31:0]    payload;
	logic           take, meta_take, line_done, dv_d;
	logic           begin_evt, end_evt, fixed_close, scan_close, full;
	logic           acq_begin, acq_halt, sw_begin, sw_end;
	lsag_bsrc_t     bsrc;
	lsag_esrc_t     esrc;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Register bus: write taken when address and data are both present
	assign wr_go = AWVALID && WVALID && !AWREADY && !BVALID;
	assign rd_go = ARVALID && !ARREADY && !RVALID;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= RESP_OKAY;
		end else begin
			AWREADY <= wr_go;
			WREADY  <= wr_go;
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP  <= (AWADDR > OFF_PAYLD || AWADDR[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cfg_q    <= CFG_RESET;
			fixed_q  <= FIXED_RESET;
			lbytes_q <= LBYTES_RESET;
			stride_q <= STRIDE_RESET;
			slots_q  <= SLOTS_RESET;
			cmd_q    <= 4'h0;
		end else begin
			cmd_q <= 4'h0;
			if (wr_go && WSTRB[0]) begin
				case (AWADDR)
					OFF_CTRL:   cmd_q <= WDATA[3:0];
					OFF_CONFIG: begin
						cfg_q[3:0] <= WDATA[3:0];
						cfg_q[CFG_FLIP] <= WDATA[CFG_FLIP];
						if (ss_q == S_OFF) begin
							cfg_q[7:5] <= WDATA[7:5];
						end
					end
					default: ;
				endcase
			end
			if (wr_go && ss_q == S_OFF) begin
				case (AWADDR)
					OFF_FIXED:  fixed_q  <= (WDATA[SZW-1:0] == '0) ? fixed_q : WDATA[SZW-1:0];
					OFF_LBYTES: lbytes_q <= WDATA[SZW-1:0];
					OFF_STRIDE: stride_q <= WDATA[SZW-1:0];
					OFF_SLOTS:  slots_q  <= (WDATA[SZW-1:0] == '0) ? slots_q : WDATA[SZW-1:0];
					default: ;
				endcase
			end
		end
	end

	assign acq_begin = cmd_q[CTL_ACQ_BEGIN];
	assign acq_halt  = cmd_q[CTL_ACQ_HALT];
	assign sw_begin  = cmd_q[CTL_SW_BEGIN];
	assign sw_end    = cmd_q[CTL_SW_END];
	assign bsrc = lsag_bsrc_t'(cfg_q[CFG_BSRC_LSB +: 2]);
	assign esrc = lsag_esrc_t'(cfg_q[CFG_ESRC_LSB +: 2]);
	assign meta_ok = cfg_q[CFG_GRAB_CYC];
	assign hdr_en  = meta_ok && cfg_q[CFG_HDR_META];
	assign lm_en   = meta_ok && cfg_q[CFG_LINE_META];
	assign repw    = lm_en ? SZW'(lbytes_q + META_BYTES) : lbytes_q;
	// Padding sits after metadata since pitch covers the grown width
	assign pitch   = (stride_q > repw) ? stride_q : repw;
	assign payload = 32'(slots_q) * 32'(pitch);

	always_comb begin
		rd_ok = 1'b1;
		rd_d  = 32'h0;
		case (ARADDR)
			OFF_CTRL:   rd_d = 32'h0;
			OFF_CONFIG: rd_d = {24'h0, cfg_q};
			OFF_FIXED:  rd_d = 32'(fixed_q);
			OFF_LBYTES: rd_d = 32'(lbytes_q);
			OFF_STRIDE: rd_d = 32'(stride_q);
			OFF_SLOTS:  rd_d = 32'(slots_q);
			OFF_STATUS: rd_d = {8'h0, 5'(ss_q), 1'b0, ls_q, 16'(lib_q)};
			OFF_REPW:   rd_d = 32'(repw);
			OFF_PAYLD:  rd_d = payload;
			default:    rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0;
			RRESP   <= RESP_OKAY;
		end else begin
			ARREADY <= rd_go;
			if (rd_go) begin
				RVALID <= 1'b1;
				RDATA  <= rd_d;
				RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// Scan control
	assign begin_evt = sw_begin || bsrc == BSRC_IMMEDIATE
		|| (bsrc == BSRC_LINE1 && INPUT_LINE_ONE_EVENT)
		|| (bsrc == BSRC_LINE2 && INPUT_LINE_TWO_EVENT);
	assign end_evt = esrc != ESRC_FIXED && (sw_end
		|| (esrc == ESRC_LINE1 && INPUT_LINE_ONE_EVENT)
		|| (esrc == ESRC_LINE2 && INPUT_LINE_TWO_EVENT));
	assign lines_n = lscan_q + 1'b1;
	assign fixed_close = esrc == ESRC_FIXED && line_done && lines_n >= fixed_q;

	always_comb begin
		ss_d = ss_q;
		case (ss_q)
			S_OFF:    if (acq_begin) ss_d = S_ARMED;
			S_ARMED:  if (begin_evt) ss_d = S_PEND;
			S_PEND:   if (LINE_BOUNDARY) ss_d = S_SCAN;
			// Begin events are not looked at here
			S_SCAN: begin
				if (fixed_close) ss_d = S_ARMED;
				else if (end_evt) ss_d = S_ENDING;
			end
			S_ENDING: if (LINE_BOUNDARY || fixed_close) ss_d = S_ARMED;
			default:  ss_d = S_OFF;
		endcase
		if (acq_halt) ss_d = S_OFF;
	end
	assign scan_close = GATE && !(ss_d == S_SCAN || ss_d == S_ENDING);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ss_q <= S_OFF;
			GATE <= 1'b0;
		end else begin
			ss_q <= ss_d;
			GATE <= ss_d == S_SCAN || ss_d == S_ENDING;
		end
	end

	// Line packing; one output word in flight keeps the ready a flop
	assign take = ls_q == L_PIX && PIX_VALID && PIX_READY;
	assign meta_take = ls_q == L_META && (!DMA_VALID || DMA_READY);
	assign line_done = (take && PIX_LAST && !lm_en) || (meta_take && midx_q == META_LAST);
	assign dv_d = take || meta_take || (DMA_VALID && !DMA_READY);
	assign slot = cfg_q[CFG_FLIP] ? slots_q - 1'b1 - lib_q : lib_q;

	always_comb begin
		ls_d = ls_q;
		case (ls_q)
			L_IDLE: if (GATE && !scan_close) ls_d = L_PIX;
			L_PIX:  if (take && PIX_LAST) ls_d = lm_en ? L_META : L_IDLE;
			L_META: if (meta_take && midx_q == META_LAST) ls_d = L_IDLE;
			default: ls_d = L_IDLE;
		endcase
		// A line not yet begun when the gate shuts must not be taken
		if (ls_q == L_PIX && boff_q == '0 && (!GATE || scan_close)) ls_d = L_IDLE;
		// Halt drops a partly moved line
		if (acq_halt) ls_d = L_IDLE;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ls_q      <= L_IDLE;
			PIX_READY <= 1'b0;
			DMA_VALID <= 1'b0;
			DMA_ADDR  <= 32'h0;
			DMA_DATA  <= 32'h0;
			boff_q    <= '0;
			midx_q    <= 2'h0;
		end else begin
			ls_q      <= ls_d;
			DMA_VALID <= dv_d;
			PIX_READY <= ls_d == L_PIX && !dv_d;
			if (take || meta_take) begin
				DMA_ADDR <= 32'(slot) * 32'(pitch) + 32'(boff_q);
				DMA_DATA <= take ? PIX_DATA : lm_hold_q[32*midx_q +: 32];
				boff_q   <= SZW'(boff_q + WORD_BYTES);
			end
			if (meta_take) begin
				midx_q <= midx_q + 2'h1;
			end
			if (ls_d == L_IDLE) begin
				boff_q <= '0;
				midx_q <= 2'h0;
			end
		end
	end

	// Buffer accounting and release
	assign full = line_done && lib_q + 1'b1 == slots_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lib_q         <= '0;
			lscan_q       <= '0;
			BUF_DONE      <= 1'b0;
			BUF_LINES     <= '0;
			BUF_HDR_VALID <= 1'b0;
			BUF_HDR_META  <= 128'h0;
		end else begin
			BUF_DONE <= 1'b0;
			if (line_done) begin
				lib_q   <= lib_q + 1'b1;
				lscan_q <= lines_n;
			end
			if (full || (scan_close && (lib_q != '0 || line_done))) begin
				BUF_DONE      <= 1'b1;
				BUF_LINES     <= line_done ? lib_q + 1'b1 : lib_q;
				BUF_HDR_VALID <= hdr_en && hdr_got_q;
				BUF_HDR_META  <= hdr_q;
			end
			if (full || scan_close) begin
				lib_q <= '0;
			end
			if (scan_close || ss_q == S_OFF) begin
				lscan_q <= '0;
			end
		end
	end

	// Metadata sampling on camera cycle begin
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lm_samp_q  <= 128'h0;
			lm_hold_q  <= 128'h0;
			hdr_q      <= 128'h0;
			hdr_pend_q <= 1'b1;
			hdr_got_q  <= 1'b0;
		end else begin
			if (CAMERA_CYCLE_BEGIN && meta_ok) begin
				lm_samp_q <= META_IN;
			end
			// Latched at the first pixel: the last cycle begin is the one that started this line
			if (take && boff_q == '0) begin
				lm_hold_q <= lm_samp_q;
			end
			if (take && boff_q == '0 && hdr_en && hdr_pend_q) begin
				hdr_q      <= lm_samp_q;
				hdr_pend_q <= 1'b0;
				hdr_got_q  <= 1'b1;
			end
			// Re-armed when the buffer fills or the scan closes, even if no buffer is released
			if (full || scan_close) begin
				hdr_pend_q <= 1'b1;
				hdr_got_q  <= 1'b0;
			end
		end
	end

	sequence s_pend_bound;
		ss_q == S_PEND && LINE_BOUNDARY && !acq_halt;
	endsequence
	sequence s_meta_word0;
		meta_take && midx_q == 2'h0;
	endsequence

	AST_BEGIN_IGNORED: assert property (ss_q == S_SCAN && !acq_halt && !fixed_close |=> ss_q != S_PEND)
		else $error("begin event disturbed a running scan");
	AST_GATE_OPEN: assert property (s_pend_bound |=> GATE && ss_q == S_SCAN)
		else $error("gate did not open at line boundary");
	AST_END_IGNORED: assert property (ss_q == S_ARMED |=> ss_q != S_ENDING)
		else $error("end event taken with no scan");
	AST_FIXED_CLOSE: assert property (fixed_close && !acq_halt |=> !GATE && ss_q == S_ARMED)
		else $error("fixed length scan did not close");
	AST_HALT: assert property (acq_halt |=> ss_q == S_OFF && !GATE ##1 !GATE)
		else $error("halt did not close the gate");
	AST_FULL_RELEASE: assert property (full |=> BUF_DONE && BUF_LINES == slots_q)
		else $error("full buffer not released");
	AST_END_RELEASE: assert property (scan_close && lib_q != '0 |=> BUF_DONE ##1 lib_q == '0)
		else $error("partial buffer not released at scan end");
	AST_FRESH: assert property (scan_close |=> lib_q == '0)
		else $error("next scan not in a fresh buffer");
	AST_NO_PIX_CLOSED: assert property (!GATE && ls_q == L_PIX |-> boff_q != '0)
		else $error("new line accepted while gate closed");
	AST_META_ORDER: assert property (s_meta_word0 |=> DMA_VALID && DMA_DATA == lm_hold_q[31:0])
		else $error("metadata word zero not first");
	AST_WIDTH: assert property (repw == (lm_en ? lbytes_q + META_BYTES : lbytes_q)
		&& payload == 32'(slots_q) * 32'(pitch))
		else $error("reported line size wrong");
endmodule
`default_nettype wire

// ### shared/lsag_pkg.sv
// Constants and types for the line-scan acquisition gate.
// Assumes one acquisition clock; register offsets are AXI4-Lite byte addresses.
package lsag_pkg;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_FIXED  = 8'h08;
	localparam logic [7:0] OFF_LBYTES = 8'h0C;
	localparam logic [7:0] OFF_STRIDE = 8'h10;
	localparam logic [7:0] OFF_SLOTS  = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_REPW   = 8'h1C;
	localparam logic [7:0] OFF_PAYLD  = 8'h20;
	// Control bits, write one to pulse
	localparam int CTL_ACQ_BEGIN = 0;
	localparam int CTL_ACQ_HALT  = 1;
	localparam int CTL_SW_BEGIN  = 2;
	localparam int CTL_SW_END    = 3;
	// Configuration fields
	localparam int CFG_BSRC_LSB  = 0;
	localparam int CFG_ESRC_LSB  = 2;
	localparam int CFG_FLIP      = 4;
	localparam int CFG_HDR_META  = 5;
	localparam int CFG_LINE_META = 6;
	localparam int CFG_GRAB_CYC  = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] FIXED_RESET  = 16'h0001;
	localparam logic [15:0] LBYTES_RESET = 16'h0100;
	localparam logic [15:0] STRIDE_RESET = 16'h0000;
	localparam logic [15:0] SLOTS_RESET  = 16'h0010;
	localparam logic [15:0] META_BYTES   = 16'h0010;
	localparam logic [15:0] WORD_BYTES   = 16'h0004;
	localparam logic [1:0]  META_LAST    = 2'h3;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [1:0] {
		BSRC_IMMEDIATE = 2'h0, BSRC_SW = 2'h1, BSRC_LINE1 = 2'h2, BSRC_LINE2 = 2'h3
	} lsag_bsrc_t;
	typedef enum logic [1:0] {
		ESRC_SW = 2'h0, ESRC_FIXED = 2'h1, ESRC_LINE1 = 2'h2, ESRC_LINE2 = 2'h3
	} lsag_esrc_t;
	typedef enum logic [2:0] {
		S_OFF = 3'b000, S_ARMED = 3'b001, S_PEND = 3'b011, S_SCAN = 3'b010, S_ENDING = 3'b110
	} lsag_scan_t;
	typedef enum logic [1:0] {
		L_IDLE = 2'b00, L_PIX = 2'b01, L_META = 2'b11
	} lsag_line_t;
endpackage
